// ==== include/tc_pkg.sv ====
// Shared constants and types of the timer/counter block
`default_nettype none
package tc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL01 = 8'h88;
   localparam logic [7:0] IDX_MODE01 = 8'h89;
   localparam logic [7:0] IDX_LO0    = 8'h8A;
   localparam logic [7:0] IDX_LO1    = 8'h8B;
   localparam logic [7:0] IDX_HI0    = 8'h8C;
   localparam logic [7:0] IDX_HI1    = 8'h8D;
   localparam logic [7:0] IDX_T2CTRL = 8'hC8;
   localparam logic [7:0] IDX_LO2    = 8'hCC;
   localparam logic [7:0] IDX_HI2    = 8'hCD;
   localparam int unsigned IDX_LSB   = 2;
   localparam int unsigned IDX_W     = 8;
   // Channel 0/1 control bits
   localparam int unsigned RUN0_BIT  = 4;
   localparam int unsigned OVF0_BIT  = 5;
   localparam int unsigned RUN1_BIT  = 6;
   localparam int unsigned OVF1_BIT  = 7;
   // Channel 2 control bits
   localparam int unsigned T2_OVF    = 7;
   localparam int unsigned T2_RX     = 5;
   localparam int unsigned T2_TX     = 4;
   localparam int unsigned T2_RUN    = 2;
   localparam int unsigned T2_CT     = 1;
   localparam int unsigned T2_CPRL   = 0;
   // Mode field encodings
   localparam logic [1:0] MODE_13      = 2'h0;
   localparam logic [1:0] MODE_16      = 2'h1;
   localparam logic [1:0] MODE_RELOAD8 = 2'h2;
   localparam logic [1:0] MODE_SPLIT   = 2'h3;
   localparam logic [4:0] PRESCALE_TOP = 5'h1F;
   localparam logic [7:0] REG_RESET    = 8'h00;
   // Pin vector positions
   localparam int unsigned PIN_N     = 5;
   localparam int unsigned CNT_N     = 3;
   localparam int unsigned PIN_IRQ_A = 3;
   localparam int unsigned PIN_IRQ_B = 4;
   // Machine cycle in oscillator periods, and its slots
   localparam int unsigned MCYCLE_OSC   = 12;
   localparam int unsigned SAMPLE_PHASE = 9;
   localparam int unsigned UPDATE_PHASE = 4;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // One channel's mode nibble
   typedef struct packed {
      logic       gate;
      logic       ct;
      logic [1:0] mode;
   } chan_cfg_t;
   // Result of one count step
   typedef struct packed {
      logic [7:0] lo;
      logic [7:0] hi;
      logic       ovf;
   } step_t;
   typedef enum logic [1:0] {T2_OFF, T2_RELOAD, T2_CAPTURE, T2_BAUD} t2_mode_t;
endpackage
`default_nettype wire

// ==== hw/timer_counter_modes.sv ====
// Three timer/counter channels behind an AXI4-Lite slave
//
// Implementation choice: the AXI4-Lite slave port.
`default_nettype none
module timer_counter_modes #(
   parameter int unsigned MCYCLE = tc_pkg::MCYCLE_OSC,
   parameter int unsigned ADDR_W = 10
) (
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   input  wire logic              countPinA,
   input  wire logic              countPinB,
   input  wire logic              countPinC,
   input  wire logic              extIrqPinA,
   input  wire logic              extIrqPinB,
   input  wire logic              irqAck0,
   input  wire logic              irqAck1,
   output logic                   ovfFlag0,
   output logic                   ovfFlag1,
   output logic                   ovfFlag2,
   output logic                   t1BaudPulse,
   output logic                   t2BaudPulse
);
   localparam int unsigned PW = $clog2(MCYCLE);
   localparam int unsigned IW = ADDR_W - tc_pkg::IDX_LSB;

   // Slots must fit inside the machine cycle
   if (MCYCLE <= tc_pkg::SAMPLE_PHASE || ADDR_W < tc_pkg::IDX_W + tc_pkg::IDX_LSB) begin : g_bad
      $error("timer_counter_modes: MCYCLE or ADDR_W too small");
   end

   logic [PW-1:0]           phase_reg;     // Oscillator period within cycle
   logic                    tick;          // Update slot
   logic                    sampleSlot;    // Pin sample slot
   logic [tc_pkg::PIN_N-1:0] pinS1_reg;    // Synchroniser stage one
   logic [tc_pkg::PIN_N-1:0] pinS2_reg;    // Synchroniser stage two
   logic [tc_pkg::CNT_N-1:0] smp_reg;      // Last slot sample
   logic [tc_pkg::CNT_N-1:0] pend_reg;     // Falling edge awaiting update
   logic                    awHeld_reg;    // Write address captured
   logic                    wHeld_reg;     // Write data captured
   logic [IW-1:0]           wrIdx_reg;     // Write index
   logic [7:0]              wrByte_reg;    // Write byte
   logic                    wrLane_reg;    // Low byte strobe
   logic                    wrFire;        // Commit cycle
   logic [IW-1:0]           arIdx;         // Read index
   logic [7:0]              rdByte;        // Read mux
   logic                    rdOk;          // Read hit
   logic [7:0]              mode01_reg;    // Mode byte of channels 0/1
   logic [7:0]              t2Ctrl_reg;    // Channel 2 control
   logic                    runBit0_reg;
   logic                    runBit1_reg;
   logic                    ovfFlag0_reg;
   logic                    ovfFlag1_reg;
   logic [7:0]              lo0_reg;
   logic [7:0]              hi0_reg;
   logic [7:0]              lo1_reg;
   logic [7:0]              hi1_reg;
   logic [7:0]              lo2_reg;
   logic [7:0]              hi2_reg;
   logic                    t1Pulse_reg;
   logic                    t2Pulse_reg;
   tc_pkg::chan_cfg_t       cfg0;
   tc_pkg::chan_cfg_t       cfg1;
   tc_pkg::step_t           s0;
   tc_pkg::step_t           s1;
   tc_pkg::t2_mode_t        t2Mode;
   logic                    split0;        // Channel 0 in split mode
   logic                    ev0;           // Count event, channel 0
   logic                    ev1;           // Count event, channel 1
   logic                    hiEv0;         // Split high byte event
   logic                    ovf1Set;
   logic                    ev2;
   logic [15:0]             cnt2Next;
   logic                    wrap2;

   // Write hit on one register, low lane only
   function automatic logic wrHit(input logic [7:0] idx);
      return wrFire && wrLane_reg && (wrIdx_reg == IW'(idx));
   endfunction

   // Known register index
   function automatic logic mapped(input logic [IW-1:0] i);
      return i == IW'(tc_pkg::IDX_CTRL01) || i == IW'(tc_pkg::IDX_MODE01) ||
             i == IW'(tc_pkg::IDX_LO0) || i == IW'(tc_pkg::IDX_LO1) ||
             i == IW'(tc_pkg::IDX_HI0) || i == IW'(tc_pkg::IDX_HI1) ||
             i == IW'(tc_pkg::IDX_T2CTRL) || i == IW'(tc_pkg::IDX_LO2) ||
             i == IW'(tc_pkg::IDX_HI2);
   endfunction

   // One count step of channel 0 or 1
   function automatic tc_pkg::step_t step(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi,
                                          input logic inc);
      tc_pkg::step_t s;
      s = '{lo: lo, hi: hi, ovf: 1'b0};
      if (inc) begin
         case (m)
            tc_pkg::MODE_13: begin
               if (lo[4:0] == tc_pkg::PRESCALE_TOP) begin
                  s.lo  = {lo[7:5], 5'h00};
                  s.hi  = hi + 8'h01;
                  s.ovf = &hi;
               end else begin
                  s.lo = lo + 8'h01;
               end
            end
            tc_pkg::MODE_16: begin
               {s.hi, s.lo} = {hi, lo} + 16'h0001;
               s.ovf        = &{hi, lo};
            end
            tc_pkg::MODE_RELOAD8: begin
               s.lo  = (&lo) ? hi : lo + 8'h01;
               s.ovf = &lo;
            end
            default: begin
               // Split low byte, eight bits
               s.lo  = lo + 8'h01;
               s.ovf = &lo;
            end
         endcase
      end
      return s;
   endfunction

   assign {cfg1, cfg0} = mode01_reg;

   // Machine cycle of MCYCLE oscillator periods
   always_ff @(posedge mclk) begin
      if (reset || phase_reg == PW'(MCYCLE - 1)) begin
         phase_reg <= '0;
      end else begin
         phase_reg <= phase_reg + 1'b1;
      end
   end
   assign tick       = phase_reg == PW'(tc_pkg::UPDATE_PHASE);
   assign sampleSlot = phase_reg == PW'(tc_pkg::SAMPLE_PHASE);

   // Two-flop synchroniser for all pins
   always_ff @(posedge mclk) begin
      if (reset) begin
         pinS1_reg <= '0;
         pinS2_reg <= '0;
      end else begin
         pinS1_reg <= {extIrqPinB, extIrqPinA, countPinC, countPinB, countPinA};
         pinS2_reg <= pinS1_reg;
      end
   end

   // sample in slot, count at update
   always_ff @(posedge mclk) begin
      if (reset) begin
         smp_reg  <= '0;
         pend_reg <= '0;
      end else if (sampleSlot) begin
         smp_reg  <= pinS2_reg[tc_pkg::CNT_N-1:0];
         pend_reg <= pend_reg | (smp_reg & ~pinS2_reg[tc_pkg::CNT_N-1:0]);
      end else if (tick) begin
         pend_reg <= '0;
      end
   end

   // Write channel: address and data in either order
   assign awready = !awHeld_reg && !bvalid;
   assign wready  = !wHeld_reg && !bvalid;
   assign wrFire  = awHeld_reg && wHeld_reg && !bvalid;
   always_ff @(posedge mclk) begin
      if (reset) begin
         awHeld_reg <= 1'b0;
         wHeld_reg  <= 1'b0;
         wrIdx_reg  <= '0;
         wrByte_reg <= tc_pkg::REG_RESET;
         wrLane_reg <= 1'b0;
         bvalid     <= 1'b0;
         bresp      <= tc_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awHeld_reg <= 1'b1;
            wrIdx_reg  <= awaddr[ADDR_W-1:tc_pkg::IDX_LSB];
         end
         if (wvalid && wready) begin
            wHeld_reg  <= 1'b1;
            wrByte_reg <= wdata[7:0];
            wrLane_reg <= wstrb[0];
         end
         // Unmapped writes answer with an error
         if (wrFire) begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            bvalid     <= 1'b1;
            bresp      <= mapped(wrIdx_reg) ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read mux; reserved bits of the channel 0/1 control read zero
   assign arIdx = araddr[ADDR_W-1:tc_pkg::IDX_LSB];
   always_comb begin
      rdByte = tc_pkg::REG_RESET;
      rdOk   = mapped(arIdx);
      case (arIdx)
         IW'(tc_pkg::IDX_CTRL01): rdByte = {ovfFlag1_reg, runBit1_reg, ovfFlag0_reg, runBit0_reg, 4'h0};
         IW'(tc_pkg::IDX_MODE01): rdByte = mode01_reg;
         IW'(tc_pkg::IDX_LO0):    rdByte = lo0_reg;
         IW'(tc_pkg::IDX_LO1):    rdByte = lo1_reg;
         IW'(tc_pkg::IDX_HI0):    rdByte = hi0_reg;
         IW'(tc_pkg::IDX_HI1):    rdByte = hi1_reg;
         IW'(tc_pkg::IDX_T2CTRL): rdByte = t2Ctrl_reg;
         IW'(tc_pkg::IDX_LO2):    rdByte = lo2_reg;
         IW'(tc_pkg::IDX_HI2):    rdByte = hi2_reg;
         default:                 rdByte = tc_pkg::REG_RESET;
      endcase
   end

   // Read channel, one word in flight
   assign arready = !rvalid;
   always_ff @(posedge mclk) begin
      if (reset) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= tc_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= {24'h00_0000, rdByte};
         rresp  <= rdOk ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // Mode byte, plain read/write
   always_ff @(posedge mclk) begin
      if (reset) begin
         mode01_reg <= tc_pkg::REG_RESET;
      end else if (wrHit(tc_pkg::IDX_MODE01)) begin
         mode01_reg <= wrByte_reg;
      end
   end

   // Count enables
   assign split0 = cfg0.mode == tc_pkg::MODE_SPLIT;
   assign ev0 = tick && runBit0_reg && (!cfg0.gate || pinS2_reg[tc_pkg::PIN_IRQ_A]) &&
                (cfg0.ct ? pend_reg[0] : 1'b1);
   assign ev1 = tick && (cfg1.mode != tc_pkg::MODE_SPLIT) && (split0 || runBit1_reg) &&
                (!cfg1.gate || pinS2_reg[tc_pkg::PIN_IRQ_B]) && (cfg1.ct ? pend_reg[1] : 1'b1);
   assign hiEv0 = tick && split0 && runBit1_reg;
   assign s0    = step(cfg0.mode, lo0_reg, hi0_reg, ev0);
   assign s1    = step(cfg1.mode, lo1_reg, hi1_reg, ev1);
   // split high byte owns flag 1
   assign ovf1Set = split0 ? (hiEv0 && (&hi0_reg)) : s1.ovf;

   // Channel 0 bytes; software write wins
   always_ff @(posedge mclk) begin
      if (reset) begin
         lo0_reg <= tc_pkg::REG_RESET;
         hi0_reg <= tc_pkg::REG_RESET;
      end else begin
         lo0_reg <= wrHit(tc_pkg::IDX_LO0) ? wrByte_reg : s0.lo;
         if (wrHit(tc_pkg::IDX_HI0)) begin
            hi0_reg <= wrByte_reg;
         end else if (hiEv0) begin
            hi0_reg <= hi0_reg + 8'h01;
         end else begin
            hi0_reg <= s0.hi;
         end
      end
   end

   // Channel 1 bytes
   always_ff @(posedge mclk) begin
      if (reset) begin
         lo1_reg <= tc_pkg::REG_RESET;
         hi1_reg <= tc_pkg::REG_RESET;
      end else begin
         lo1_reg <= wrHit(tc_pkg::IDX_LO1) ? wrByte_reg : s1.lo;
         hi1_reg <= wrHit(tc_pkg::IDX_HI1) ? wrByte_reg : s1.hi;
      end
   end

   // Run bits and flags; a set beats any clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         runBit0_reg  <= 1'b0;
         runBit1_reg  <= 1'b0;
         ovfFlag0_reg <= 1'b0;
         ovfFlag1_reg <= 1'b0;
      end else if (wrHit(tc_pkg::IDX_CTRL01)) begin
         runBit0_reg  <= wrByte_reg[tc_pkg::RUN0_BIT];
         runBit1_reg  <= wrByte_reg[tc_pkg::RUN1_BIT];
         ovfFlag0_reg <= wrByte_reg[tc_pkg::OVF0_BIT] || s0.ovf;
         ovfFlag1_reg <= wrByte_reg[tc_pkg::OVF1_BIT] || ovf1Set;
      end else begin
         ovfFlag0_reg <= s0.ovf || (ovfFlag0_reg && !irqAck0);
         ovfFlag1_reg <= ovf1Set || (ovfFlag1_reg && !irqAck1);
      end
   end

   // channel 1 overflow to serial port
   always_ff @(posedge mclk) begin
      if (reset) begin
         t1Pulse_reg <= 1'b0;
      end else begin
         t1Pulse_reg <= s1.ovf;
      end
   end

   always_comb begin
      if (!t2Ctrl_reg[tc_pkg::T2_RUN]) begin
         t2Mode = tc_pkg::T2_OFF;
      end else if (t2Ctrl_reg[tc_pkg::T2_RX] || t2Ctrl_reg[tc_pkg::T2_TX]) begin
         t2Mode = tc_pkg::T2_BAUD;
      end else if (t2Ctrl_reg[tc_pkg::T2_CPRL]) begin
         t2Mode = tc_pkg::T2_CAPTURE;
      end else begin
         t2Mode = tc_pkg::T2_RELOAD;
      end
   end

   assign ev2      = tick && (t2Mode != tc_pkg::T2_OFF) && (t2Ctrl_reg[tc_pkg::T2_CT] ? pend_reg[2] : 1'b1);
   assign cnt2Next = {hi2_reg, lo2_reg} + 16'h0001;
   assign wrap2    = ev2 && (&{hi2_reg, lo2_reg});

   // Channel 2 bytes
   always_ff @(posedge mclk) begin
      if (reset) begin
         lo2_reg <= tc_pkg::REG_RESET;
         hi2_reg <= tc_pkg::REG_RESET;
      end else begin
         if (wrHit(tc_pkg::IDX_LO2)) begin
            lo2_reg <= wrByte_reg;
         end else if (ev2) begin
            lo2_reg <= cnt2Next[7:0];
         end
         if (wrHit(tc_pkg::IDX_HI2)) begin
            hi2_reg <= wrByte_reg;
         end else if (ev2) begin
            hi2_reg <= cnt2Next[15:8];
         end
      end
   end

   // Channel 2 control; flag not set as baud source
   always_ff @(posedge mclk) begin
      if (reset) begin
         t2Ctrl_reg  <= tc_pkg::REG_RESET;
         t2Pulse_reg <= 1'b0;
      end else begin
         if (wrHit(tc_pkg::IDX_T2CTRL)) begin
            t2Ctrl_reg <= wrByte_reg;
         end
         if (wrap2 && t2Mode != tc_pkg::T2_BAUD) begin
            t2Ctrl_reg[tc_pkg::T2_OVF] <= 1'b1;
         end
         t2Pulse_reg <= wrap2 && t2Mode == tc_pkg::T2_BAUD;
      end
   end

   assign ovfFlag0    = ovfFlag0_reg;
   assign ovfFlag1    = ovfFlag1_reg;
   assign ovfFlag2    = t2Ctrl_reg[tc_pkg::T2_OVF];
   assign t1BaudPulse = t1Pulse_reg;
   assign t2BaudPulse = t2Pulse_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   gate_hold_a: assert property ((cfg0.gate && !pinS2_reg[tc_pkg::PIN_IRQ_A] && !wrHit(tc_pkg::IDX_LO0))
      |=> $stable(lo0_reg)) else $error("gated channel 0 counted");
   pin_src_a: assert property ((tick && cfg0.ct && !pend_reg[0] && !wrHit(tc_pkg::IDX_LO0))
      |=> $stable(lo0_reg)) else $error("counted without pin edge");
   prescale_a: assert property ((ev0 && cfg0.mode == tc_pkg::MODE_13 && lo0_reg[4:0] != tc_pkg::PRESCALE_TOP
      && !wrHit(tc_pkg::IDX_HI0)) |=> $stable(hi0_reg)) else $error("prescaler did not hold high byte");
   ovf_13_a: assert property ((ev0 && cfg0.mode == tc_pkg::MODE_13 && (&hi0_reg)
      && lo0_reg[4:0] == tc_pkg::PRESCALE_TOP) |=> ovfFlag0_reg && hi0_reg == 8'h00) else $error("no rollover");
   run_keep_a: assert property ($rose(runBit0_reg) |-> $stable(lo0_reg))
      else $error("start changed count");
   wide_count_a: assert property ((ev0 && cfg0.mode == tc_pkg::MODE_16 && !wrHit(tc_pkg::IDX_LO0)
      && !wrHit(tc_pkg::IDX_HI0)) |=> {hi0_reg, lo0_reg} == $past({hi0_reg, lo0_reg}) + 16'h0001)
      else $error("16-bit step wrong");
   reload_low_a: assert property ((ev0 && cfg0.mode == tc_pkg::MODE_RELOAD8 && (&lo0_reg)
      && !wrHit(tc_pkg::IDX_LO0) && !wrHit(tc_pkg::IDX_HI0)) |=> lo0_reg == $past(hi0_reg)
      && $stable(hi0_reg) && ovfFlag0_reg) else $error("reload wrong");
   hold_ch1_a: assert property ((cfg1.mode == tc_pkg::MODE_SPLIT && !wrHit(tc_pkg::IDX_LO1)
      && !wrHit(tc_pkg::IDX_HI1)) |=> $stable({hi1_reg, lo1_reg})) else $error("channel 1 counted in mode 3");
   split_flag_a: assert property ((hiEv0 && (&hi0_reg) && !wrHit(tc_pkg::IDX_CTRL01)) |=> ovfFlag1_reg)
      else $error("split high overflow lost");
   baud_noflag_a: assert property ((t2Mode == tc_pkg::T2_BAUD && !ovfFlag2
      && !wrHit(tc_pkg::IDX_T2CTRL)) |=> !ovfFlag2) else $error("flag set as baud source");
   t2_rate_a: assert property ((tick && t2Mode == tc_pkg::T2_RELOAD && !t2Ctrl_reg[tc_pkg::T2_CT]
      && !wrHit(tc_pkg::IDX_LO2) && !wrHit(tc_pkg::IDX_HI2)) |=> {hi2_reg, lo2_reg} == $past(cnt2Next))
      else $error("channel 2 missed a cycle");
   edge_pend_a: assert property ((sampleSlot && smp_reg[2] && !pinS2_reg[2]) |=> pend_reg[2])
      else $error("edge not caught");
   ack_clear_a: assert property ((irqAck0 && !s0.ovf && !wrHit(tc_pkg::IDX_CTRL01)) |=> !ovfFlag0_reg)
      else $error("acknowledge did not clear");
endmodule
`default_nettype wire

// ==== sim/pin_model.sv ====
// Behavioural model of the count and gate pins
`default_nettype none
module pin_model #(
   parameter int unsigned MCYCLE = 12
) (
   input  wire logic       mclk,
   output logic [2:0]      countPin,
   output logic [1:0]      gatePin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Count pins idle high, gates closed
   initial begin
      countPin = 3'h7;
      gatePin  = 2'h0;
   end
   // level hold time
   // Two machine cycles per level, so no edge slips between samples
   task automatic falls(input int ch, input int n);
      repeat (n) begin
         @(posedge mclk) countPin[ch] <= 1'b0;
         repeat (2 * MCYCLE) @(posedge mclk);
         countPin[ch] <= 1'b1;
         repeat (2 * MCYCLE) @(posedge mclk);
      end
   endtask
   // Gate level changes only after an edge
   task automatic gate(input int ch, input logic v);
      @(posedge mclk) gatePin[ch] <= v;
   endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the timer/counter block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned MC = 12;   // Machine cycle in clocks
   logic        mclk, reset, awvalid, wvalid, bready, arvalid, rready, irqAck0, irqAck1;
   logic        awready, wready, bvalid, arready, rvalid, ovf0, ovf1, ovf2, b1, b2;
   logic [9:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, gatePin;
   logic [2:0]  countPin;
   logic [4:0]  evt;                  // Flags and baud pulses to wait on
   int          errTotal, comparisons;
   assign evt = {b2, b1, ovf2, ovf1, ovf0};
   timer_counter_modes #(.MCYCLE(MC), .ADDR_W(10)) DUT (
      .mclk(mclk), .reset(reset), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'h1),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .countPinA(countPin[0]), .countPinB(countPin[1]), .countPinC(countPin[2]),
      .extIrqPinA(gatePin[0]), .extIrqPinB(gatePin[1]), .irqAck0(irqAck0), .irqAck1(irqAck1),
      .ovfFlag0(ovf0), .ovfFlag1(ovf1), .ovfFlag2(ovf2), .t1BaudPulse(b1), .t2BaudPulse(b2));
   pin_model #(.MCYCLE(MC)) PINS (.mclk(mclk), .countPin(countPin), .gatePin(gatePin));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Verdict and end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         errTotal++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // A wait that ran out ends the run
   task automatic hang(input logic ok);
      if (ok !== 1'b1) begin
         errTotal++;
         $display("wrong value at %0t: wait ran out", $time);
         results();
      end
   endtask
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 200);
      bready <= 1'b0;
      hang(bvalid);
      chk({6'h00, bresp}, {6'h00, tc_pkg::RESP_OKAY});
   endtask
   // Read and compare data and response
   task automatic rdr(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er = tc_pkg::RESP_OKAY);
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 200);
      rready <= 1'b0;
      hang(rvalid);
      chk(rdata[7:0], exp);
      chk({6'h00, rresp}, {6'h00, er});
   endtask
   // Bounded wait for one flag or pulse
   task automatic waitEvt(input int i, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (evt[i] !== 1'b1 && n < lim);
      comparisons++;
      hang(evt[i]);
   endtask
   initial begin
      {reset, awvalid, wvalid, bready, arvalid, rready, irqAck0, irqAck1} = 8'h80;
      {awaddr, araddr, wdata} = '0;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      rdr(tc_pkg::IDX_MODE01, 8'h00);
      rdr(8'h40, 8'h00, tc_pkg::RESP_SLVERR);
      // Preset count runs out in 13-bit, 16-bit and reload modes
      for (int m = 0; m < 3; m++) begin
         wr(tc_pkg::IDX_HI0, 8'hFF);
         wr(tc_pkg::IDX_LO0, 8'hFD);
         wr(tc_pkg::IDX_MODE01, m[7:0]);
         wr(tc_pkg::IDX_CTRL01, 8'h10);
         waitEvt(0, 4 * MC);
         wr(tc_pkg::IDX_CTRL01, 8'h20);
         rdr(tc_pkg::IDX_LO0, (m == 0) ? 8'hE0 : (m == 1) ? 8'h00 : 8'hFF);
         rdr(tc_pkg::IDX_HI0, (m == 2) ? 8'hFF : 8'h00);
         @(posedge mclk) irqAck0 <= 1'b1;
         @(posedge mclk) irqAck0 <= 1'b0;
         @(posedge mclk) chk({7'h00, ovf0}, 8'h00);
      end
      // Reload keeps the high byte
      wr(tc_pkg::IDX_HI1, 8'hF0);
      wr(tc_pkg::IDX_LO1, 8'hFE);
      wr(tc_pkg::IDX_MODE01, 8'h20);
      wr(tc_pkg::IDX_CTRL01, 8'h40);
      waitEvt(1, 3 * MC);
      wr(tc_pkg::IDX_CTRL01, 8'h00);
      rdr(tc_pkg::IDX_LO1, 8'hF0);
      rdr(tc_pkg::IDX_HI1, 8'hF0);
      // Pin edges counted only while the gate is open
      wr(tc_pkg::IDX_LO0, 8'h00);
      wr(tc_pkg::IDX_MODE01, 8'h0D);
      wr(tc_pkg::IDX_CTRL01, 8'h10);
      PINS.falls(0, 2);
      rdr(tc_pkg::IDX_LO0, 8'h00);
      PINS.gate(0, 1'b1);
      PINS.falls(0, 3);
      rdr(tc_pkg::IDX_LO0, 8'h03);
      // Split mode: high byte of channel 0 on the channel 1 flag
      wr(tc_pkg::IDX_HI0, 8'hFE);
      // Low byte on its idle pin, so it cannot count before run0 drops
      wr(tc_pkg::IDX_MODE01, 8'h37);
      wr(tc_pkg::IDX_CTRL01, 8'h40);
      waitEvt(1, 3 * MC);
      rdr(tc_pkg::IDX_LO1, 8'hF0);
      rdr(tc_pkg::IDX_LO0, 8'h03);
      wr(tc_pkg::IDX_MODE01, 8'h23);
      waitEvt(3, 20 * MC);
      chk({7'h00, ovf1}, 8'h01);
      @(posedge mclk) irqAck1 <= 1'b1;
      @(posedge mclk) irqAck1 <= 1'b0;
      @(posedge mclk) chk({7'h00, ovf1}, 8'h00);
      // Channel 2 timer, then baud mode without its flag
      wr(tc_pkg::IDX_LO2, 8'hFE);
      wr(tc_pkg::IDX_HI2, 8'hFF);
      wr(tc_pkg::IDX_T2CTRL, 8'h04);
      waitEvt(2, 3 * MC);
      wr(tc_pkg::IDX_T2CTRL, 8'h00);
      wr(tc_pkg::IDX_LO2, 8'hFE);
      wr(tc_pkg::IDX_HI2, 8'hFF);
      wr(tc_pkg::IDX_T2CTRL, 8'h24);
      waitEvt(4, 3 * MC);
      chk({7'h00, ovf2}, 8'h00);
      // Channel 2 counting pin edges in capture mode
      wr(tc_pkg::IDX_T2CTRL, 8'h00);
      wr(tc_pkg::IDX_LO2, 8'hFE);
      wr(tc_pkg::IDX_HI2, 8'hFF);
      wr(tc_pkg::IDX_T2CTRL, 8'h07);
      PINS.falls(2, 2);
      chk({7'h00, ovf2}, 8'h01);
      rdr(tc_pkg::IDX_LO2, 8'h00);
      results();
   end
endmodule
`default_nettype wire
